// ==== design/accel_output_fifo.sv ====
// axis output bytes and 32-deep sample queue with register port
// Function
// - axis byte pairs at 0x32/0x33 x, 0x34/0x35 y, 0x36/0x37 z.
// - samples twos complement, low byte at lower address.
// - output byte layout follows the format control setting.
// - control bits 7:6 pick queue mode; 00 bypasses the queue.
// - fill mode accepts until 32 held, then drops new samples.
// - stream mode keeps newest 32, overwriting oldest when full.
// - trigger mode keeps pre-trigger samples, then fills until full.
// - control bit 5 picks first or second interrupt as trigger.
// - threshold sets watermark level in fill and stream modes.
// - in trigger mode threshold sets samples kept before trigger.
// - writing zero threshold sets the watermark flag at once.
// - state bit 7 shows trigger seen, bit 6 reads zero.
// - state bits 5:0 give number of samples held.
// - an access to data bytes pops one level outside bypass mode; burst reads needed.
// - 32 stored plus one in output stage, 33 available.
// - ready, watermark, overrun flags set on events, clear on data read.
// - sleep suppresses data ready and queue pushes.
`timescale 1ns/10ps
module accel_output_fifo (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    smp_clk,
  input  wire accel_fifo_pkg::raw_type smp_raw,
  input  wire logic                    fmt_justify,
  input  wire logic                    first_irq_output,
  input  wire logic                    second_irq_output,
  input  wire logic                    sleep_active,
  input  wire logic                    xfer_active,
  input  wire logic                    reg_rd,
  input  wire logic                    reg_wr,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  output logic      [7:0]              reg_rdata,
  output logic                         data_ready_flag,
  output logic                         watermark_flag,
  output logic                         overrun_flag,
  output logic                         trigger_seen_flag
);
  localparam int SW = $bits(accel_fifo_pkg::sample_type);

  // link side synchronisers, first stage read only by second
  logic                    clk_s1_q, clk_s2_q, clk_s3_q;
  accel_fifo_pkg::raw_type raw_s1_q, raw_s2_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      raw_s1_q <= '0;
      raw_s2_q <= '0;
    end else begin
      clk_s1_q <= smp_clk;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      raw_s1_q <= smp_raw;
      raw_s2_q <= raw_s1_q;
    end
  end

  // sign extend or left justify one axis
  function automatic logic [accel_fifo_pkg::AXIS_W-1:0] fmt_axis(
    input logic [accel_fifo_pkg::RAW_W-1:0] raw,
    input logic                             just);
    if (just) fmt_axis = {raw, {accel_fifo_pkg::EXT_W{1'b0}}};
    else fmt_axis = {{accel_fifo_pkg::EXT_W{raw[accel_fifo_pkg::RAW_W-1]}},
                     raw};
  endfunction

  logic                       cap_fire, buf_in_ready, buf_valid, buf_ready;
  accel_fifo_pkg::sample_type cap_word, buf_word;

  // capture on a rising link edge; data settled long before it
  always_comb begin
    cap_fire   = clk_s2_q & ~clk_s3_q;
    cap_word.x = fmt_axis(raw_s2_q.x, fmt_justify);
    cap_word.y = fmt_axis(raw_s2_q.y, fmt_justify);
    cap_word.z = fmt_axis(raw_s2_q.z, fmt_justify);
  end

  two_slot_buffer #(.W(SW)) u_buf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (cap_fire),
    .in_ready  (buf_in_ready),
    .in_data   (cap_word),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_word)
  );

  // queue and output-stage state
  accel_fifo_pkg::ctl_type    ctl_q, ctl_d;
  accel_fifo_pkg::sample_type out_q, out_d, snap_q, snap_d, ram_q;
  logic [accel_fifo_pkg::CNT_W-1:0] cnt_q, cnt_d, avail;
  logic [accel_fifo_pkg::PTR_W-1:0] wp_q, wp_d, rp_q, rp_d;
  logic out_v_q, out_v_d, pend_q, pend_d, xfer_q, seen_q, seen_d;
  logic trig_q, trig_d, trg_src_q, drdy_q, drdy_d, wm_q, wm_d;
  logic ovr_q, ovr_d;
  logic [7:0] rdata_q, rdata_d;
  logic bypass, full, take, wr_en, drop, load, pop, flush, ovr_ev;
  logic data_rd, ctl_wr, trg_src, trg_edge;

  sample_ram #(.W(SW), .AW(accel_fifo_pkg::PTR_W)) u_ram (
    .core_clk  (core_clk),
    .wr_en     (wr_en),
    .wr_addr   (wp_q),
    .wr_data   (buf_word),
    .rd_addr   (rp_q),
    .rd_data_q (ram_q)
  );

  // queue movement; loading the output stage stalls the buffer
  always_comb begin
    bypass  = (ctl_q.mode == accel_fifo_pkg::MODE_BYPASS);
    full    = (cnt_q == accel_fifo_pkg::DEPTH_CNT);
    data_rd = reg_rd & (reg_addr >= accel_fifo_pkg::ADDR_X_LOW) &
              (reg_addr <= accel_fifo_pkg::ADDR_Z_HIGH);
    ctl_wr  = reg_wr & (reg_addr == accel_fifo_pkg::ADDR_CTL);
    flush   = ctl_wr & (reg_reg_mode(reg_wdata) != ctl_q.mode);
    pop     = xfer_q & ~xfer_active & seen_q & ~bypass & out_v_q;
    load    = ~bypass & ~out_v_q & ~pend_q & (cnt_q != '0) & ~flush;
    buf_ready = ~load;
    take    = buf_valid & buf_ready;
    wr_en   = 1'b0;
    drop    = 1'b0;
    ovr_ev  = cap_fire & ~buf_in_ready;
    out_d   = out_q;
    out_v_d = out_v_q;
    if (take && bypass) begin
      out_d   = buf_word;
      out_v_d = 1'b1;
    end else if (take && !sleep_active && !flush) begin
      unique case (ctl_q.mode)
        accel_fifo_pkg::MODE_FILL: begin
          wr_en  = ~full;
          ovr_ev = ovr_ev | full;
        end
        accel_fifo_pkg::MODE_STREAM: begin
          wr_en  = 1'b1;
          drop   = full;
          ovr_ev = ovr_ev | full;
        end
        accel_fifo_pkg::MODE_TRIGGER: begin
          if (!trig_q) begin
            wr_en = 1'b1;
            drop  = (cnt_q != '0) &
                    (cnt_q >= {1'b0, ctl_q.thr});
          end else begin
            wr_en  = ~full;
            ovr_ev = ovr_ev | full;
          end
        end
        default: ;
      endcase
    end
    if (pend_q) begin
      out_d   = ram_q;
      out_v_d = 1'b1;
    end
    if (pop) out_v_d = 1'b0;
    pend_d = load & ~flush;
    cnt_d  = cnt_q + {5'h0, wr_en} - {5'h0, drop} - {5'h0, load};
    wp_d   = wp_q + {4'h0, wr_en};
    rp_d   = rp_q + {4'h0, drop | load};
    if (flush) begin
      cnt_d   = '0;
      wp_d    = '0;
      rp_d    = '0;
      pend_d  = 1'b0;
      out_v_d = 1'b0;
    end
  end

  // mode field of a control byte
  function automatic logic [1:0] reg_reg_mode(input logic [7:0] b);
    accel_fifo_pkg::ctl_type c;
    c = b;
    reg_reg_mode = c.mode;
  endfunction

  // control register, trigger and status flags
  always_comb begin
    ctl_d    = ctl_wr ? accel_fifo_pkg::ctl_type'(reg_wdata) : ctl_q;
    trg_src  = ctl_q.trig_sel ? second_irq_output : first_irq_output;
    trg_edge = trg_src & ~trg_src_q;
    trig_d   = (trig_q & ~ctl_wr) |
               ((ctl_q.mode == accel_fifo_pkg::MODE_TRIGGER) &
                trg_edge);
    avail    = bypass ? '0 : cnt_q + {5'h0, out_v_q};
    // set wins over the read clear; level sets re-arm after a read
    drdy_d   = (drdy_q & ~data_rd) | (~sleep_active &
               (bypass ? (take & ~pend_q) : (avail != '0)));
    wm_d     = (wm_q & ~data_rd) | (ctl_q.thr == '0) |
               ((ctl_q.mode == accel_fifo_pkg::MODE_FILL ||
                 ctl_q.mode == accel_fifo_pkg::MODE_STREAM) &&
                (avail >= {1'b0, ctl_q.thr}));
    ovr_d    = (ovr_q & ~data_rd) | ovr_ev;
  end

  // read path; first data byte of an access freezes the sample
  always_comb begin
    seen_d  = xfer_active ? (seen_q | data_rd) : 1'b0;
    snap_d  = (data_rd && !seen_q) ? out_q : snap_q;
    rdata_d = rdata_q;
    if (reg_rd) begin
      unique case (reg_addr)
        accel_fifo_pkg::ADDR_X_LOW:  rdata_d = snap_d.x[7:0];
        accel_fifo_pkg::ADDR_X_HIGH: rdata_d = snap_d.x[15:8];
        accel_fifo_pkg::ADDR_Y_LOW:  rdata_d = snap_d.y[7:0];
        accel_fifo_pkg::ADDR_Y_HIGH: rdata_d = snap_d.y[15:8];
        accel_fifo_pkg::ADDR_Z_LOW:  rdata_d = snap_d.z[7:0];
        accel_fifo_pkg::ADDR_Z_HIGH: rdata_d = snap_d.z[15:8];
        accel_fifo_pkg::ADDR_CTL:    rdata_d = ctl_q;
        accel_fifo_pkg::ADDR_STATE:  rdata_d = {trig_q, 1'b0, avail};
        default:                     rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctl_q     <= accel_fifo_pkg::CTL_RESET;
      out_q     <= '0;
      snap_q    <= '0;
      out_v_q   <= 1'b0;
      pend_q    <= 1'b0;
      cnt_q     <= '0;
      wp_q      <= '0;
      rp_q      <= '0;
      xfer_q    <= 1'b0;
      seen_q    <= 1'b0;
      trig_q    <= 1'b0;
      trg_src_q <= 1'b0;
      drdy_q    <= 1'b0;
      wm_q      <= 1'b0;
      ovr_q     <= 1'b0;
      rdata_q   <= 8'h00;
    end else begin
      ctl_q     <= ctl_d;
      out_q     <= out_d;
      snap_q    <= snap_d;
      out_v_q   <= out_v_d;
      pend_q    <= pend_d;
      cnt_q     <= cnt_d;
      wp_q      <= wp_d;
      rp_q      <= rp_d;
      xfer_q    <= xfer_active;
      seen_q    <= seen_d;
      trig_q    <= trig_d;
      trg_src_q <= trg_src;
      drdy_q    <= drdy_d;
      wm_q      <= wm_d;
      ovr_q     <= ovr_d;
      rdata_q   <= rdata_d;
    end
  end

  assign reg_rdata         = rdata_q;
  assign data_ready_flag   = drdy_q;
  assign watermark_flag    = wm_q;
  assign overrun_flag      = ovr_q;
  assign trigger_seen_flag = trig_q;

  // checks on the queue and register behaviour
  fill_stays_full_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (ctl_q.mode == accel_fifo_pkg::MODE_FILL) && full && take && !flush
    |=> cnt_q == accel_fifo_pkg::DEPTH_CNT)
    else $error("fill mode wrote into a full queue");

  stream_overwrite_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (ctl_q.mode == accel_fifo_pkg::MODE_STREAM) && full && take &&
    !sleep_active && !flush
    |=> (cnt_q == accel_fifo_pkg::DEPTH_CNT) && ovr_q)
    else $error("stream mode did not overwrite oldest");

  state_bit_six_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    reg_rd && reg_addr == accel_fifo_pkg::ADDR_STATE
    |=> reg_rdata[6] == 1'b0 && reg_rdata[7] == $past(trig_q))
    else $error("queue state byte top bits wrong");

  bypass_count_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    bypass && reg_rd && reg_addr == accel_fifo_pkg::ADDR_STATE
    |=> reg_rdata[5:0] == 6'h00)
    else $error("bypass reported queued entries");

  zero_thr_wm_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    ctl_wr && reg_wdata[4:0] == 5'h00 |-> ##2 watermark_flag)
    else $error("zero threshold did not raise watermark");

  trig_capture_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (ctl_q.mode == accel_fifo_pkg::MODE_TRIGGER) && !ctl_wr &&
    $rose(ctl_q.trig_sel ? second_irq_output : first_irq_output)
    |=> trigger_seen_flag)
    else $error("trigger event not recorded");

  pop_clears_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    pop |=> !out_v_q ##1 (out_v_q || cnt_q == '0 || pend_q))
    else $error("access end did not pop one level");

  sleep_hold_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    sleep_active && !bypass && !flush |=> cnt_q <= $past(cnt_q))
    else $error("queue grew while asleep");

  overrun_set_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    ovr_ev |=> overrun_flag [*2])
    else $error("overrun event lost");
endmodule

// ==== common/accel_fifo_pkg.sv ====
// shared constants and types for the axis sample queue
package accel_fifo_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_X_LOW  = 8'h32;
  localparam logic [7:0] ADDR_X_HIGH = 8'h33;
  localparam logic [7:0] ADDR_Y_LOW  = 8'h34;
  localparam logic [7:0] ADDR_Y_HIGH = 8'h35;
  localparam logic [7:0] ADDR_Z_LOW  = 8'h36;
  localparam logic [7:0] ADDR_Z_HIGH = 8'h37;
  localparam logic [7:0] ADDR_CTL    = 8'h38;
  localparam logic [7:0] ADDR_STATE  = 8'h39;
  localparam logic [7:0] CTL_RESET   = 8'h00;
  // queue geometry
  localparam int DEPTH = 32;
  localparam int PTR_W = 5;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 6'h20;
  // sample widths
  localparam int RAW_W  = 10;
  localparam int AXIS_W = 16;
  localparam int EXT_W  = AXIS_W - RAW_W;
  // queue mode codes
  localparam logic [1:0] MODE_BYPASS  = 2'h0;
  localparam logic [1:0] MODE_FILL    = 2'h1;
  localparam logic [1:0] MODE_STREAM  = 2'h2;
  localparam logic [1:0] MODE_TRIGGER = 2'h3;

  typedef struct packed {
    logic [1:0] mode;
    logic       trig_sel;
    logic [4:0] thr;
  } ctl_type;

  typedef struct packed {
    logic [AXIS_W-1:0] z;
    logic [AXIS_W-1:0] y;
    logic [AXIS_W-1:0] x;
  } sample_type;

  typedef struct packed {
    logic [RAW_W-1:0] z;
    logic [RAW_W-1:0] y;
    logic [RAW_W-1:0] x;
  } raw_type;
endpackage

// ==== design/sample_ram.sv ====
// queue storage with registered read data
`timescale 1ns/10ps
module sample_ram #(
  parameter int W  = 48,
  parameter int AW = 5
) (
  input  wire logic          core_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data_q
);
  logic [W-1:0] mem [2**AW];

  // plain storage, no reset needed on the data path
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end
endmodule

// ==== design/two_slot_buffer.sv ====
// two-entry valid/ready buffer
`timescale 1ns/10ps
module two_slot_buffer #(
  parameter int W = 48
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  logic [W-1:0] head_q, head_d, tail_q, tail_d;
  logic [1:0]   cnt_q, cnt_d;
  logic         push, pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = head_q;

  // head always holds the oldest word
  always_comb begin
    head_d = head_q;
    tail_d = tail_q;
    cnt_d  = cnt_q;
    push   = in_valid & in_ready;
    pop    = out_ready & out_valid;
    unique case ({push, pop})
      2'b10: begin
        if (cnt_q == 2'h0) head_d = in_data;
        else tail_d = in_data;
        cnt_d = cnt_q + 2'h1;
      end
      2'b01: begin
        head_d = tail_q;
        cnt_d  = cnt_q - 2'h1;
      end
      2'b11: begin
        if (cnt_q == 2'h1) begin
          head_d = in_data;
        end else begin
          head_d = tail_q;
          tail_d = in_data;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q  <= 2'h0;
      head_q <= '0;
      tail_q <= '0;
    end else begin
      cnt_q  <= cnt_d;
      head_q <= head_d;
      tail_q <= tail_d;
    end
  end
endmodule

// ==== tb/sample_source.sv ====
// front-end model: framed sample clock carrying raw axis words
`timescale 1ns/10ps
module sample_source (
  output logic                    smp_clk,
  output accel_fifo_pkg::raw_type smp_raw
);
  // link idles low with no frame in flight
  initial begin
    smp_clk = 1'b0;
    smp_raw = '0;
  end

  // one 160 ns frame per sample; the odd offset keeps the edge away
  // from core edges, and the word flips after the frame so stale data
  // never passes for a fresh sample
  task automatic send(input accel_fifo_pkg::raw_type r);
    smp_raw = r;
    #53 smp_clk = 1'b1;
    #80 smp_clk = 1'b0;
    #27 smp_raw = ~r;
  endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the axis sample queue
`timescale 1ns/10ps
module tb;
  logic core_clk, rst_n, smp_clk, fmt_justify, sleep_active;
  logic first_irq_output, second_irq_output, xfer_active;
  logic reg_rd, reg_wr, rd_seen, quiet;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic data_ready_flag, watermark_flag, overrun_flag, trigger_seen_flag;
  accel_fifo_pkg::raw_type smp_raw;
  accel_fifo_pkg::raw_type smp[0:39];
  logic [7:0] exp_q[$];
  int fail_count, num_checks, cycles;

  // core clock, 10 ns period
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  sample_source src (
    .smp_clk (smp_clk),
    .smp_raw (smp_raw)
  );

  accel_output_fifo uut (
    .core_clk          (core_clk),
    .rst_n             (rst_n),
    .smp_clk           (smp_clk),
    .smp_raw           (smp_raw),
    .fmt_justify       (fmt_justify),
    .first_irq_output  (first_irq_output),
    .second_irq_output (second_irq_output),
    .sleep_active      (sleep_active),
    .xfer_active       (xfer_active),
    .reg_rd            (reg_rd),
    .reg_wr            (reg_wr),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_rdata         (reg_rdata),
    .data_ready_flag   (data_ready_flag),
    .watermark_flag    (watermark_flag),
    .overrun_flag      (overrun_flag),
    .trigger_seen_flag (trigger_seen_flag)
  );

  // expected axis value: left justified or sign extended
  function automatic logic [15:0] expand(input logic [9:0] v,
                                         input logic j);
    expand = j ? {v, 6'h00} : {{6{v[9]}}, v};
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] e);
    num_checks++;
    if (reg_rdata !== e) begin
      fail_count++;
      $display("[ERR] reg_rdata exp %h got %h", e, reg_rdata);
    end
  endtask

  task automatic chk_flag(input string n, input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // strobes idle for a cycle after each access, never re-raised at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd = 1'b1;
    reg_addr = a;
    exp_q.push_back(e);
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
  endtask

  // six-byte burst inside one access, then wait for the reload
  task automatic burst(input accel_fifo_pkg::raw_type s, input logic j);
    logic [47:0] b;
    b = {expand(s.z, j), expand(s.y, j), expand(s.x, j)};
    xfer_active = 1'b1;
    cyc(1);
    for (int i = 0; i < 6; i++) begin
      reg_rd = 1'b1;
      reg_addr = accel_fifo_pkg::ADDR_X_LOW + 8'(i);
      exp_q.push_back(b[8*i +: 8]);
      cyc(1);
    end
    reg_rd = 1'b0;
    xfer_active = 1'b0;
    cyc(4);
  endtask

  // unchecked data read, only to clear the sticky flags
  task automatic clr;
    quiet = 1'b1;
    xfer_active = 1'b1;
    reg_rd = 1'b1;
    reg_addr = accel_fifo_pkg::ADDR_X_LOW;
    cyc(1);
    reg_rd = 1'b0;
    xfer_active = 1'b0;
    quiet = 1'b0;
    cyc(4);
  endtask

  task automatic push(input int i);
    src.send(smp[i]);
    @(negedge core_clk);
  endtask

  task automatic pulse(input logic sel);
    if (sel) second_irq_output = 1'b1;
    else first_irq_output = 1'b1;
    cyc(2);
    first_irq_output = 1'b0;
    second_irq_output = 1'b0;
    cyc(3);
  endtask

  // read answers land one cycle after the strobe; compare oldest note
  always @(posedge core_clk) rd_seen <= reg_rd & ~quiet;
  always @(negedge core_clk) begin
    if (rd_seen) begin
      chk_byte(exp_q.pop_front());
    end
  end

  // hang guard, far above the expected run length
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    rst_n = 1'b0;
    {fmt_justify, sleep_active, xfer_active, quiet} = 4'h0;
    {first_irq_output, second_irq_output, reg_rd, reg_wr} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    {fail_count, num_checks, cycles} = '0;
    void'($urandom(80721));
    foreach (smp[i]) smp[i] = 30'($urandom);
    cyc(16);
    rst_n = 1'b1;
    cyc(3);
    chk_flag("watermark_flag", watermark_flag, 1'b1);
    wr(accel_fifo_pkg::ADDR_STATE, 8'hFF);
    rd(accel_fifo_pkg::ADDR_CTL, 8'h00);
    rd(accel_fifo_pkg::ADDR_STATE, 8'h00);
    rd(8'h3A, 8'h00);
    // bypass: newest sample in both output formats
    push(0);
    cyc(4);
    burst(smp[0], 1'b0);
    fmt_justify = 1'b1;
    push(1);
    cyc(4);
    burst(smp[1], 1'b1);
    fmt_justify = 1'b0;
    // fill-and-stop: overfill, then pop in order
    wr(accel_fifo_pkg::ADDR_CTL, 8'h44);
    rd(accel_fifo_pkg::ADDR_CTL, 8'h44);
    for (int i = 2; i < 38; i++) push(i);
    cyc(8);
    rd(accel_fifo_pkg::ADDR_STATE, 8'h21);
    chk_flag("overrun_flag", overrun_flag, 1'b1);
    burst(smp[2], 1'b0);
    chk_flag("overrun_flag", overrun_flag, 1'b0);
    burst(smp[3], 1'b0);
    // stream: overfill keeps the count at the ceiling
    wr(accel_fifo_pkg::ADDR_CTL, 8'h84);
    for (int i = 0; i < 36; i++) push(i);
    cyc(8);
    rd(accel_fifo_pkg::ADDR_STATE, 8'h21);
    chk_flag("overrun_flag", overrun_flag, 1'b1);
    // trigger on the second source, three queued and one staged sample kept before it
    wr(accel_fifo_pkg::ADDR_CTL, 8'hE3);
    for (int i = 0; i < 6; i++) push(i);
    cyc(8);
    pulse(1'b0);
    chk_flag("trigger_seen_flag", trigger_seen_flag, 1'b0);
    pulse(1'b1);
    chk_flag("trigger_seen_flag", trigger_seen_flag, 1'b1);
    rd(accel_fifo_pkg::ADDR_STATE, 8'h84);
    wr(accel_fifo_pkg::ADDR_CTL, 8'hE3);
    chk_flag("trigger_seen_flag", trigger_seen_flag, 1'b0);
    // sleep: no queue push, no data ready
    wr(accel_fifo_pkg::ADDR_CTL, 8'h44);
    clr();
    sleep_active = 1'b1;
    push(6);
    cyc(8);
    chk_flag("data_ready_flag", data_ready_flag, 1'b0);
    rd(accel_fifo_pkg::ADDR_STATE, 8'h00);
    sleep_active = 1'b0;
    // watermark at four entries, then forced by a zero threshold
    chk_flag("watermark_flag", watermark_flag, 1'b0);
    for (int i = 7; i < 11; i++) push(i);
    cyc(8);
    chk_flag("watermark_flag", watermark_flag, 1'b1);
    chk_flag("data_ready_flag", data_ready_flag, 1'b1);
    burst(smp[7], 1'b0);
    // level still at threshold during the burst, so the set wins there
    chk_flag("watermark_flag", watermark_flag, 1'b1);
    clr();
    chk_flag("watermark_flag", watermark_flag, 1'b0);
    wr(accel_fifo_pkg::ADDR_CTL, 8'h40);
    chk_flag("watermark_flag", watermark_flag, 1'b1);
    cyc(2);
    wrap_up();
  end
endmodule
